// >>> design/param_cmd_pkg.sv
// What this block does
// RL1 - nine bytes: addr, instr, type, bank, value, checksum
// RL2 - instruction 5, motor zero: write axis parameter
// RL3 - axis parameters live in volatile storage only
// RL4 - instruction 6 direct: reply value, accumulator untouched
// RL5 - standalone read also loads the accumulator
// RL6 - instruction 7 copies axis parameter to eeprom
// RL7 - instruction 8 reloads axis parameter from eeprom
// RL8 - power-up reloads all axis parameters first
// RL9 - instruction 9 writes global parameter in bank
// RL10 - bank 0 settings, 2 user, 3 interrupt
// RL11 - bank 0 writes persist to eeprom automatically
// RL12 - every global parameter in every bank readable; code reads banks 0/2/3 only, other banks get status 4
// RL13 - instruction 10 reads global, banks 0/2/3
// RL14 - success replies status 100, value for reads
// RL15 - checksum is low byte of eight-byte sum
package param_cmd_pkg;
    localparam logic [7:0] INSTR_SET_AXIS = 8'h05;
    localparam logic [7:0] INSTR_GET_AXIS = 8'h06;
    localparam logic [7:0] INSTR_STORE_AXIS = 8'h07;
    localparam logic [7:0] INSTR_RESTORE_AXIS = 8'h08;
    localparam logic [7:0] INSTR_SET_GLOBAL = 8'h09;
    localparam logic [7:0] INSTR_GET_GLOBAL = 8'h0A;
    localparam logic [7:0] BANK_SETTINGS = 8'h00;
    localparam logic [7:0] BANK_USER = 8'h02;
    localparam logic [7:0] BANK_IRQ = 8'h03;
    localparam logic [7:0] STATUS_OK = 8'h64;
    localparam logic [7:0] STATUS_BAD_CHECKSUM = 8'h01;
    localparam logic [7:0] STATUS_BAD_INSTR = 8'h02;
    localparam logic [7:0] STATUS_BAD_TYPE = 8'h03;
    localparam logic [7:0] STATUS_BAD_VALUE = 8'h04;
    localparam logic [7:0] REPLY_ADDR = 8'h02;
    localparam logic [7:0] MODULE_ADDR = 8'h01;
    localparam logic [3:0] FRAME_LAST = 4'h8;
    localparam logic [1:0] PSEL_AXIS = 2'h0;
    localparam logic [1:0] PSEL_SETTINGS = 2'h1;
    localparam logic [1:0] PSEL_USER = 2'h2;
    localparam logic [1:0] PSEL_IRQ = 2'h3;
    localparam int MEM_AW = 10;
    localparam int MEM_DW = 32;
endpackage

// >>> design/param_store.sv
`timescale 1ns/10ps
module param_store
(
    input wire logic clock,
    input wire logic we,
    input wire logic [param_cmd_pkg::MEM_AW-1:0] waddr,
    input wire logic [param_cmd_pkg::MEM_DW-1:0] wdata,
    input wire logic [param_cmd_pkg::MEM_AW-1:0] raddr,
    output logic [param_cmd_pkg::MEM_DW-1:0] rdata
);
    // no reset: contents are volatile and undefined until loaded
    logic [param_cmd_pkg::MEM_DW-1:0] mem [0:(1<<param_cmd_pkg::MEM_AW)-1];

    always_ff @(posedge clock)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule // param_store

// >>> design/param_cmd.sv
`timescale 1ns/10ps
module param_cmd
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic standalone,
    output logic reply_valid,
    output logic [7:0] reply_status,
    output logic [7:0] reply_instr,
    output logic [31:0] reply_value,
    output logic [31:0] accu,
    output logic ready,
    output logic ee_req,
    output logic ee_write,
    output logic [9:0] ee_addr,
    output logic [31:0] ee_wdata,
    input wire logic ee_ack,
    input wire logic [31:0] ee_rdata
);
    typedef enum logic [2:0]
    {
        ST_BOOT = 3'h0,
        ST_IDLE = 3'h1,
        ST_READ = 3'h3,
        ST_EXEC = 3'h2,
        ST_EE = 3'h6,
        ST_BOOT_RD = 3'h4
    } state_t;

    state_t state_ff, nxt_state;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [7:0] instr_ff, nxt_instr, type_ff, nxt_type, bank_ff, nxt_bank;
    logic [31:0] value_ff, nxt_value;
    logic [7:0] sum_ff, nxt_sum;
    logic [9:0] boot_ff, nxt_boot;
    logic reply_valid_ff, nxt_reply_valid;
    logic [7:0] status_ff, nxt_status, rinstr_ff, nxt_rinstr;
    logic [31:0] rvalue_ff, nxt_rvalue, accu_ff, nxt_accu;
    logic req_ff, nxt_req, wr_ff, nxt_wr;
    logic ready_ff, nxt_ready;
    logic [9:0] eaddr_ff, nxt_eaddr;
    logic [31:0] edata_ff, nxt_edata;
    logic [1:0] rx_sync_ff;
    logic [7:0] byte_s1_ff, byte_s2_ff;
    logic rx_seen_ff;
    logic mem_we;
    logic [9:0] mem_waddr, mem_raddr;
    logic [31:0] mem_wdata, mem_rdata;
    logic [9:0] sel_addr;
    logic sel_ok;
    logic strobe;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_sync_ff <= 2'h0;
            byte_s1_ff <= 8'h00;
            byte_s2_ff <= 8'h00;
            rx_seen_ff <= 1'b0;
        end
        else
        begin
            rx_sync_ff <= {rx_sync_ff[0], rx_valid};
            byte_s1_ff <= rx_byte;
            byte_s2_ff <= byte_s1_ff;
            rx_seen_ff <= rx_sync_ff[1];
        end
    end
    // byte must be steady while the level is high; edge marks one byte
    assign strobe = rx_sync_ff[1] & ~rx_seen_ff;

    // ----------------------------------------
    // parameter memory map
    // ----------------------------------------
    // axis 0..255, bank 0 at 256, bank 2 at 512, bank 3 at 768
    always_comb
    begin
        sel_ok = 1'b1;
        sel_addr = {param_cmd_pkg::PSEL_AXIS, type_ff};
        if (instr_ff == param_cmd_pkg::INSTR_SET_GLOBAL ||
            instr_ff == param_cmd_pkg::INSTR_GET_GLOBAL)
        begin
            unique case (bank_ff) // RL10
                param_cmd_pkg::BANK_SETTINGS: sel_addr = {param_cmd_pkg::PSEL_SETTINGS, type_ff};
                param_cmd_pkg::BANK_USER: sel_addr = {param_cmd_pkg::PSEL_USER, type_ff};
                param_cmd_pkg::BANK_IRQ: sel_addr = {param_cmd_pkg::PSEL_IRQ, type_ff};
                default: sel_ok = 1'b0;
            endcase
        end
        else if (bank_ff != 8'h00)
        begin
            sel_ok = 1'b0; // RL2
        end
    end

    // RL3: sram copy only; eeprom is the outside store
    param_store u_store
    (
        .clock(clock),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );
    assign mem_raddr = sel_addr;

    // ----------------------------------------
    // command sequencer
    // ----------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_instr = instr_ff;
        nxt_type = type_ff;
        nxt_bank = bank_ff;
        nxt_value = value_ff;
        nxt_sum = sum_ff;
        nxt_boot = boot_ff;
        nxt_reply_valid = 1'b0;
        nxt_status = status_ff;
        nxt_rinstr = rinstr_ff;
        nxt_rvalue = rvalue_ff;
        nxt_accu = accu_ff;
        nxt_req = req_ff;
        nxt_wr = wr_ff;
        nxt_eaddr = eaddr_ff;
        nxt_edata = edata_ff;
        mem_we = 1'b0;
        mem_waddr = sel_addr;
        mem_wdata = value_ff;
        unique case (state_ff)
            ST_BOOT:
            begin
                nxt_req = 1'b1; // RL8
                nxt_wr = 1'b0;
                nxt_eaddr = boot_ff;
                nxt_state = ST_BOOT_RD;
            end
            ST_BOOT_RD:
            begin
                if (ee_ack)
                begin
                    nxt_req = 1'b0;
                    mem_we = 1'b1; // RL8
                    mem_waddr = boot_ff;
                    mem_wdata = ee_rdata;
                    nxt_boot = boot_ff + 10'h001;
                    // only the axis block is reloaded at start
                    nxt_state = (boot_ff[7:0] == 8'hFF) ? ST_IDLE : ST_BOOT;
                end
            end
            ST_IDLE:
            begin
                if (strobe)
                begin
                    unique case (cnt_ff) // RL1
                        4'h1: nxt_instr = byte_s2_ff;
                        4'h2: nxt_type = byte_s2_ff;
                        4'h3: nxt_bank = byte_s2_ff;
                        4'h4, 4'h5, 4'h6, 4'h7: nxt_value = {value_ff[23:0], byte_s2_ff};
                        default: ;
                    endcase
                    nxt_sum = sum_ff + byte_s2_ff; // RL15
                    nxt_cnt = cnt_ff + 4'h1;
                    if (cnt_ff == 4'h0)
                    begin
                        nxt_sum = byte_s2_ff;
                    end
                    if (cnt_ff == param_cmd_pkg::FRAME_LAST)
                    begin
                        nxt_cnt = 4'h0;
                        nxt_rinstr = instr_ff;
                        nxt_rvalue = 32'h0000_0000;
                        if (byte_s2_ff != sum_ff)
                        begin
                            nxt_status = param_cmd_pkg::STATUS_BAD_CHECKSUM; // RL15
                            nxt_reply_valid = 1'b1;
                        end
                        else
                        begin
                            nxt_state = ST_READ;
                        end
                    end
                end
            end
            ST_READ:
            begin
                nxt_state = ST_EXEC; // sync memory read latency
            end
            ST_EXEC:
            begin
                nxt_status = param_cmd_pkg::STATUS_OK; // RL14
                nxt_state = ST_IDLE;
                nxt_reply_valid = 1'b1;
                if (instr_ff < param_cmd_pkg::INSTR_SET_AXIS ||
                    instr_ff > param_cmd_pkg::INSTR_GET_GLOBAL)
                begin
                    nxt_status = param_cmd_pkg::STATUS_BAD_INSTR;
                end
                else if (!sel_ok)
                begin
                    nxt_status = param_cmd_pkg::STATUS_BAD_VALUE;
                end
                else
                begin
                    unique case (instr_ff)
                        param_cmd_pkg::INSTR_SET_AXIS: mem_we = 1'b1; // RL2
                        param_cmd_pkg::INSTR_GET_AXIS, param_cmd_pkg::INSTR_GET_GLOBAL:
                        begin
                            nxt_rvalue = mem_rdata; // RL4 RL12 RL13
                            if (standalone)
                            begin
                                nxt_accu = mem_rdata; // RL5
                            end
                        end
                        param_cmd_pkg::INSTR_SET_GLOBAL:
                        begin
                            mem_we = 1'b1; // RL9
                            if (bank_ff == param_cmd_pkg::BANK_SETTINGS)
                            begin
                                nxt_req = 1'b1; // RL11
                                nxt_wr = 1'b1;
                                nxt_eaddr = sel_addr;
                                nxt_edata = value_ff;
                                nxt_reply_valid = 1'b0;
                                nxt_state = ST_EE;
                            end
                        end
                        param_cmd_pkg::INSTR_STORE_AXIS:
                        begin
                            nxt_req = 1'b1; // RL6
                            nxt_wr = 1'b1;
                            nxt_eaddr = sel_addr;
                            nxt_edata = mem_rdata;
                            nxt_reply_valid = 1'b0;
                            nxt_state = ST_EE;
                        end
                        default:
                        begin
                            nxt_req = 1'b1; // RL7
                            nxt_wr = 1'b0;
                            nxt_eaddr = sel_addr;
                            nxt_reply_valid = 1'b0;
                            nxt_state = ST_EE;
                        end
                    endcase
                end
            end
            default:
            begin
                if (ee_ack)
                begin
                    nxt_req = 1'b0;
                    nxt_reply_valid = 1'b1; // RL14
                    nxt_state = ST_IDLE;
                    if (!wr_ff)
                    begin
                        mem_we = 1'b1; // RL7
                        mem_waddr = eaddr_ff;
                        mem_wdata = ee_rdata;
                    end
                end
            end
        endcase
        // registered so the pin carries no state decode glitch
        nxt_ready = (nxt_state == ST_IDLE);
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_ff <= ST_BOOT;
            cnt_ff <= 4'h0;
            instr_ff <= 8'h00;
            type_ff <= 8'h00;
            bank_ff <= 8'h00;
            value_ff <= 32'h0000_0000;
            sum_ff <= 8'h00;
            boot_ff <= 10'h000;
            reply_valid_ff <= 1'b0;
            status_ff <= 8'h00;
            rinstr_ff <= 8'h00;
            rvalue_ff <= 32'h0000_0000;
            accu_ff <= 32'h0000_0000;
            req_ff <= 1'b0;
            wr_ff <= 1'b0;
            eaddr_ff <= 10'h000;
            edata_ff <= 32'h0000_0000;
            ready_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            instr_ff <= nxt_instr;
            type_ff <= nxt_type;
            bank_ff <= nxt_bank;
            value_ff <= nxt_value;
            sum_ff <= nxt_sum;
            boot_ff <= nxt_boot;
            reply_valid_ff <= nxt_reply_valid;
            status_ff <= nxt_status;
            rinstr_ff <= nxt_rinstr;
            rvalue_ff <= nxt_rvalue;
            accu_ff <= nxt_accu;
            req_ff <= nxt_req;
            wr_ff <= nxt_wr;
            eaddr_ff <= nxt_eaddr;
            edata_ff <= nxt_edata;
            ready_ff <= nxt_ready;
        end
    end

    assign reply_valid = reply_valid_ff;
    assign reply_status = status_ff;
    assign reply_instr = rinstr_ff;
    assign reply_value = rvalue_ff;
    assign accu = accu_ff;
    assign ready = ready_ff;
    assign ee_req = req_ff;
    assign ee_write = wr_ff;
    assign ee_addr = eaddr_ff;
    assign ee_wdata = edata_ff;
endmodule // param_cmd

// >>> test/param_cmd_monitor.sv
`timescale 1ns/10ps
// ------
// protocol checks
// ------
module param_cmd_monitor
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic standalone,
    input wire logic reply_valid,
    input wire logic [7:0] reply_status,
    input wire logic [7:0] reply_instr,
    input wire logic [31:0] reply_value,
    input wire logic [31:0] accu,
    input wire logic ready,
    input wire logic ee_req,
    input wire logic ee_write,
    input wire logic [9:0] ee_addr,
    input wire logic ee_ack
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    pulse_once_a: assert property (reply_valid |=> !reply_valid)
        else $error("reply pulse too long");
    ok_instr_a: assert property (reply_valid && reply_status == 8'h64 |->
        reply_instr inside {[8'h05:8'h0A]}) else $error("ok on foreign instr");
    zero_value_a: assert property (reply_valid && reply_instr inside {8'h05, 8'h07, 8'h08,
        8'h09} |-> reply_value == 32'h0) else $error("value not zero");
    ee_hold_a: assert property (ee_req && !ee_ack |=> ee_req && $stable(ee_addr)
        && $stable(ee_write)) else $error("eeprom request dropped");
    ee_release_a: assert property (ee_req && ee_ack |=> !ee_req)
        else $error("eeprom request kept");
    store_done_a: assert property (reply_valid && reply_instr == 8'h07 && reply_status == 8'h64
        |-> $past(ee_ack) && $past(ee_write)) else $error("store without write");
    restore_done_a: assert property (reply_valid && reply_instr == 8'h08 && reply_status == 8'h64
        |-> $past(ee_ack) && !$past(ee_write)) else $error("restore without read");
    accu_keep_a: assert property ((!standalone)[*4] |=> $stable(accu))
        else $error("accu moved in direct mode");
    accu_load_a: assert property (reply_valid && standalone && reply_instr == 8'h06
        && reply_status == 8'h64 |-> ##[0:1] accu == reply_value) else $error("accu not loaded");
    boot_read_a: assert property ($rose(rst_b) |=> ee_req && !ee_write && ee_addr == 10'h000)
        else $error("boot reload missing");
    boot_busy_a: assert property ($rose(rst_b) |-> !ready [*8])
        else $error("ready before reload");
endmodule // param_cmd_monitor

// >>> test/eeprom_model.sv
`timescale 1ns/10ps
// ------
// eeprom behind the block
// ------
module eeprom_model
(
    input wire logic clock,
    input wire logic ee_req,
    input wire logic ee_write,
    input wire logic [9:0] ee_addr,
    input wire logic [31:0] ee_wdata,
    input wire logic slow,
    output logic ee_ack,
    output logic [31:0] ee_rdata
);
    logic [31:0] mem [0:1023];
    logic [2:0] wait_ff;
    initial
    begin
        ee_ack = 1'b0;
        ee_rdata = 32'h0;
        wait_ff = 3'h0;
        for (int i = 0; i < 1024; i++)
            mem[i] = 32'hA5000000 | i;
    end
    always @(posedge clock)
    begin
        // data toggles so a stale read is never mistaken for valid
        ee_rdata <= ~ee_rdata;
        if (ee_ack || !ee_req)
        begin
            ee_ack <= 1'b0;
            wait_ff <= 3'h0;
        end
        else if (wait_ff == (slow ? 3'h4 : 3'h0))
        begin
            ee_ack <= 1'b1;
            ee_rdata <= mem[ee_addr];
            if (ee_write)
                mem[ee_addr] <= ee_wdata;
        end
        else
            wait_ff <= wait_ff + 3'h1;
    end
endmodule // eeprom_model

// >>> test/param_cmd_test.sv
`timescale 1ns/10ps
module param_cmd_test;
    logic clock, rst_b, rx_valid, standalone, slow, reply_valid, ready, ee_req, ee_write, ee_ack;
    logic [7:0] rx_byte, reply_status, reply_instr;
    logic [31:0] reply_value, accu, ee_wdata, ee_rdata;
    logic [9:0] ee_addr;
    int fail_count, num_checks, replies;
    param_cmd i_param_cmd (.clock, .rst_b, .rx_valid, .rx_byte, .standalone, .reply_valid,
        .reply_status, .reply_instr, .reply_value, .accu, .ready, .ee_req, .ee_write, .ee_addr,
        .ee_wdata, .ee_ack, .ee_rdata);
    eeprom_model i_eeprom_model (.clock, .ee_req, .ee_write, .ee_addr, .ee_wdata, .slow,
        .ee_ack, .ee_rdata);
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock)
        if (reply_valid)
            replies <= replies + 1;
    // ------
    // helpers
    // ------
    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_ready(input int limit, input int n0);
        for (int i = 0; i < limit; i++)
        begin
            @(negedge clock);
            if (ready === 1'b1 && replies >= n0)
            begin
                @(posedge clock);
                return;
            end
        end
        check("ready wait", 32'h1, 32'h0);
        end_of_test();
    endtask
    // bytes held 3 cycles high and 3 low, as the synchroniser needs
    task automatic frame(input logic [7:0] ins, typ, bank, input logic [31:0] val,
        input logic [7:0] err);
        logic [7:0] b [9];
        int n0;
        b = '{8'h01, ins, typ, bank, val[31:24], val[23:16], val[15:8], val[7:0], err};
        n0 = replies + 1;
        for (int i = 0; i < 8; i++)
            b[8] += b[i];
        for (int i = 0; i < 9; i++)
        begin
            rx_byte <= b[i];
            rx_valid <= 1'b1;
            repeat (3) @(posedge clock);
            rx_valid <= 1'b0;
            repeat (3) @(posedge clock);
        end
        wait_ready(100, n0);
    endtask
    // ------
    // scenarios
    // ------
    task automatic boot_reload;
        frame(8'h06, 8'h03, 8'h00, 32'h0, 8'h00);
        check("boot value", 32'hA5000003, reply_value);
        check("echo instr", 32'h06, reply_instr);
    endtask
    task automatic axis_rw;
        frame(8'h05, 8'h04, 8'h00, 32'h3E8, 8'h00);
        check("set status", 32'h64, reply_status);
        check("volatile", 32'hA5000004, i_eeprom_model.mem[4]);
        standalone <= 1'b1;
        frame(8'h06, 8'h04, 8'h00, 32'h0, 8'h00);
        check("get value", 32'h3E8, reply_value);
        check("accu load", 32'h3E8, accu);
        standalone <= 1'b0;
    endtask
    task automatic store_restore;
        slow <= 1'b1;
        frame(8'h07, 8'h04, 8'h00, 32'hFFFFFFFF, 8'h00);
        check("store", 32'h3E8, i_eeprom_model.mem[4]);
        frame(8'h05, 8'h04, 8'h00, 32'h7, 8'h00);
        frame(8'h06, 8'h04, 8'h00, 32'h0, 8'h00);
        check("direct read", 32'h7, reply_value);
        check("accu kept", 32'h3E8, accu);
        frame(8'h08, 8'h04, 8'h00, 32'hFFFFFFFF, 8'h00);
        frame(8'h06, 8'h04, 8'h00, 32'h0, 8'h00);
        check("restore", 32'h3E8, reply_value);
        slow <= 1'b0;
    endtask
    task automatic globals;
        logic [7:0] bk [3];
        bk = '{8'h00, 8'h02, 8'h03};
        for (int i = 0; i < 3; i++)
        begin
            frame(8'h09, 8'h42, bk[i], 32'h1000 + i, 8'h00);
            frame(8'h0A, 8'h42, bk[i], 32'hFFFFFFFF, 8'h00);
            check("global read", 32'h1000 + i, reply_value);
        end
        check("bank0 saved", 32'h1000, i_eeprom_model.mem[10'h142]);
        check("bank2 not saved", 32'hA5000242, i_eeprom_model.mem[10'h242]);
    endtask
    task automatic refusals;
        frame(8'h06, 8'h04, 8'h00, 32'h0, 8'h01);
        check("bad sum", 32'h1, reply_status);
        frame(8'h0B, 8'h04, 8'h00, 32'h0, 8'h00);
        check("bad instr", 32'h2, reply_status);
        frame(8'h05, 8'h04, 8'h01, 32'h9, 8'h00);
        check("bad motor", 32'h4, reply_status);
        frame(8'h0A, 8'h42, 8'h01, 32'h0, 8'h00);
        check("bad bank", 32'h4, reply_status);
        frame(8'h06, 8'h04, 8'h00, 32'h0, 8'h00);
        check("no write", 32'h3E8, reply_value);
    endtask
    // second reset in mid-run: sram value lost, eeprom copy reloaded
    task automatic power_cycle;
        frame(8'h05, 8'h05, 8'h00, 32'h55, 8'h00);
        rst_b <= 1'b0;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        wait_ready(3000, replies);
        frame(8'h06, 8'h05, 8'h00, 32'h0, 8'h00);
        check("sram lost", 32'hA5000005, reply_value);
    endtask
    initial
    begin
        rst_b = 1'b0;
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        standalone = 1'b0;
        slow = 1'b0;
        fail_count = 0;
        num_checks = 0;
        replies = 0;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        wait_ready(3000, 0);
        boot_reload();
        axis_rw();
        store_restore();
        globals();
        refusals();
        power_cycle();
        end_of_test();
    end
endmodule // param_cmd_test
bind param_cmd param_cmd_monitor i_param_cmd_monitor (.clock, .rst_b, .standalone, .reply_valid,
    .reply_status, .reply_instr, .reply_value, .accu, .ready, .ee_req, .ee_write, .ee_addr,
    .ee_ack);
